/* rtl/tsc_pkg.sv */
// tsc_pkg: constants, states and carriers for the transport-stream MAC convergence block.
// assumes one byte clock shared with the MAC sublayer and the modulator/demodulator logic.
package tsc_pkg;
	// packet geometry
	localparam logic [7:0] PKT_LAST = 8'hBB;
	localparam logic [15:0] PAYLOAD_LEN = 16'h00B8;
	localparam logic [7:0] IDX_SYNC = 8'h00;
	localparam logic [7:0] IDX_PID_HI = 8'h01;
	localparam logic [7:0] IDX_PID_LO = 8'h02;
	localparam logic [7:0] IDX_CTRL = 8'h03;
	localparam logic [7:0] IDX_POINTER = 8'h04;
	// header field values and positions
	localparam logic [7:0] SYNC_BYTE = 8'h47;
	localparam logic [7:0] STUFF_BYTE = 8'hFF;
	localparam logic [12:0] MAC_PID = 13'h1FFE;
	localparam logic [12:0] NULL_PID = 13'h1FFF;
	localparam logic [1:0] AFC_PAYLOAD = 2'h1;
	localparam int PSTART_BIT = 6;
	localparam int TEI_BIT = 7;
	localparam int AFC_LSB = 4;
	// sync lock thresholds
	localparam logic [3:0] LOCK_GOOD = 4'h5;
	localparam logic [3:0] LOCK_BAD = 4'h9;
	// apb register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TX_PKTS = 8'h08;
	localparam logic [7:0] ADDR_RX_FRAMES = 8'h0C;
	localparam int CTRL_TX_EN = 0;
	localparam int CTRL_RX_EN = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int STAT_LOCKED = 0;
	localparam int STAT_RX_FRAME = 1;
	localparam int STAT_TX_FRAME = 2;

	typedef enum logic [1:0] {TSC_SYNC_HUNT, TSC_SYNC_CONFIRM, TSC_SYNC_LOCKED} tsc_sync_t;
	typedef enum logic {TSC_DF_HUNT, TSC_DF_FRAME} tsc_df_t;

	// one byte of a MAC frame offered for transmission
	typedef struct packed {
		logic sof;
		logic ts;
		logic [15:0] len;
		logic [7:0] data;
	} tsc_mac_tx_t;

	// one byte towards the modulator or towards the MAC deframer client
	typedef struct packed {
		logic first;
		logic [7:0] data;
	} tsc_byte_t;
endpackage

/* rtl/tsc_top.sv */
// tsc_top: headend packet framer and modem packet deframer for MAC traffic in transport packets.
// assumes all ports are on pclk; the MAC sublayer keeps a started frame valid byte after byte.
// Contract
// R01: stream is back-to-back 188-byte packets, 4 header bytes then 184 payload.
// R02: every packet starts with sync byte 0x47; receiver aligns on it.
// R03: MAC packets use PID 0x1FFE; only those reach the deframer.
// R04: adaptation field control is 01 on MAC packets; all payload.
// R05: with payload-start flag set, first payload byte is the offset, not data.
// R06: offset byte sits at packet byte five when payload-start flag is one.
// R07: gaps are filled with 0xFF; the modem skips them when hunting.
// R08: frame control byte 0xFF is illegal and counts as filler.
// R09: modem skips exactly the offset count of bytes before hunting.
// R10: headend sets payload-start flag whenever a frame could begin in packet.
// R11: offset points at first new frame or at filler before it.
// R12: frames may start anywhere, span packets, and share a packet.
// R13: offset zero means hunting starts right after the offset byte.
// R14: a frame arriving late may follow filler in the same packet.
// R15: send null packets instead of MAC packets holding only filler.
// R16: offset in a continuing frame's next packet points after its tail.
// R17: timestamp is inserted into the sync message as it leaves.
// R18: lock after five correct sync bytes spaced 188 bytes apart.
// R19: lose lock and re-hunt after nine incorrect sync bytes.
// R20: packet without payload-start flag is all continuation, no offset.
// R21: without lock, discard payload and abandon a partial frame.
`timescale 1ns/1ps
module tsc_top
	import tsc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// mac frames to send
	input wire tsc_pkg::tsc_mac_tx_t mac_tx,
	input wire logic mac_tx_valid,
	output logic mac_tx_ready,
	input wire logic [31:0] ts_count,
	// byte stream to the modulator
	output tsc_pkg::tsc_byte_t phy_tx,
	output logic phy_tx_valid,
	input wire logic phy_tx_ready,
	// byte stream from the demodulator
	input wire logic [7:0] phy_rx_data,
	input wire logic phy_rx_valid,
	// deframed mac bytes
	output tsc_pkg::tsc_byte_t mac_rx,
	output logic mac_rx_valid,
	output logic mac_rx_abort,
	input wire logic mac_rx_eof
);
	import tsc_pkg::*;

	logic [1:0] ctrl_reg, ctrl_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [31:0] tx_pkts_reg, tx_pkts_next, rx_frames_reg, rx_frames_next;
	logic addr_ok;

	// transmit state
	logic [7:0] tx_idx_reg, tx_idx_next;
	logic [3:0] cc_reg, cc_next;
	logic pstart_reg, pstart_next, null_reg, null_next;
	logic [15:0] rem_reg, rem_next;
	logic [1:0] ts_left_reg, ts_left_next;
	logic [31:0] ts_cap_reg, ts_cap_next;
	tsc_byte_t phy_reg, phy_next;
	logic phy_valid_reg, phy_valid_next;
	logic tx_adv, take_mac;
	logic [12:0] pid_sel;
	logic [7:0] tx_byte;

	// receive state
	tsc_sync_t sync_reg, sync_next;
	tsc_df_t df_reg, df_next, df_eff;
	logic [7:0] rx_idx_reg, rx_idx_next, skip_reg, skip_next;
	logic [3:0] good_reg, good_next, bad_reg, bad_next;
	logic hdr_pstart_reg, hdr_pstart_next, pkt_ok_reg, pkt_ok_next;
	logic [4:0] pid_hi_reg, pid_hi_next;
	tsc_byte_t mrx_reg, mrx_next;
	logic mrx_valid_reg, mrx_valid_next, abort_reg, abort_next;
	logic sync_pos, sync_good, locked, payload_pos;

	// register access; answers in the access cycle, data latched in setup
	always_comb begin
		ctrl_next = ctrl_reg;
		prdata_next = prdata_reg;
		addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
			(paddr == ADDR_TX_PKTS) || (paddr == ADDR_RX_FRAMES);
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				ADDR_CTRL: prdata_next = {30'h0, ctrl_reg};
				ADDR_STATUS: prdata_next = {29'h0, (rem_reg != 16'h0000),
					(df_reg == TSC_DF_FRAME), locked};
				ADDR_TX_PKTS: prdata_next = tx_pkts_reg;
				ADDR_RX_FRAMES: prdata_next = rx_frames_reg;
				default: prdata_next = 32'h0;
			endcase
		end
		if (psel && penable && pwrite && (paddr == ADDR_CTRL))
			ctrl_next = pwdata[1:0];
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_reg;

	// headend framer: continuous packets, byte index walks 0..187
	assign tx_adv = ctrl_reg[CTRL_TX_EN] && (!phy_valid_reg || phy_tx_ready); // [R01]
	assign pid_sel = null_reg ? NULL_PID : MAC_PID;
	assign take_mac = tx_adv && !null_reg && (tx_idx_reg > IDX_CTRL) &&
		!(pstart_reg && tx_idx_reg == IDX_POINTER) && mac_tx_valid &&
		((rem_reg != 16'h0000) || mac_tx.sof); // [R12] [R14]
	assign mac_tx_ready = take_mac;

	always_comb begin
		tx_idx_next = tx_idx_reg;
		cc_next = cc_reg;
		pstart_next = pstart_reg;
		null_next = null_reg;
		rem_next = rem_reg;
		ts_left_next = ts_left_reg;
		ts_cap_next = ts_cap_reg;
		tx_pkts_next = tx_pkts_reg;
		phy_next = phy_reg;
		phy_valid_next = phy_valid_reg && !phy_tx_ready;
		tx_byte = STUFF_BYTE; // [R07]
		if (tx_adv) begin
			tx_idx_next = (tx_idx_reg == PKT_LAST) ? IDX_SYNC : tx_idx_reg + 8'h01;
			phy_valid_next = 1'b1;
			if (tx_idx_reg == IDX_SYNC) begin
				tx_byte = SYNC_BYTE; // [R02]
				// nothing in flight and nothing offered: a null packet keeps the mux free
				null_next = (rem_reg == 16'h0000) && !(mac_tx_valid && mac_tx.sof); // [R15]
				// flag whenever the running frame ends inside this payload [R10] [R20]
				pstart_next = !null_next && (rem_reg < PAYLOAD_LEN);
				tx_pkts_next = tx_pkts_reg + 32'h1;
			end else if (tx_idx_reg == IDX_PID_HI) begin
				tx_byte = {1'b0, pstart_reg, 1'b0, pid_sel[12:8]}; // [R03]
			end else if (tx_idx_reg == IDX_PID_LO) begin
				tx_byte = pid_sel[7:0]; // [R03]
			end else if (tx_idx_reg == IDX_CTRL) begin
				tx_byte = {2'b00, AFC_PAYLOAD, cc_reg}; // [R04]
				if (!null_reg)
					cc_next = cc_reg + 4'h1;
			end else if (pstart_reg && tx_idx_reg == IDX_POINTER) begin
				// remaining tail length; zero when no frame is running [R06] [R11] [R16]
				tx_byte = rem_reg[7:0];
			end else if (take_mac) begin
				tx_byte = mac_tx.data;
				rem_next = (rem_reg != 16'h0000) ? rem_reg - 16'h0001 : mac_tx.len - 16'h0001;
				// timestamp goes out as the bytes leave, msb first [R17]
				// a frame cut short must not hand its leftover timestamp bytes to the next one
				if (ts_left_reg != 2'h0 && rem_reg != 16'h0000) begin
					tx_byte = ts_cap_reg[{ts_left_reg - 2'h1, 3'h0} +: 8];
					ts_left_next = ts_left_reg - 2'h1;
				end else if (mac_tx.ts) begin
					tx_byte = ts_count[31:24];
					ts_cap_next = ts_count;
					ts_left_next = 2'h3;
				end else begin
					ts_left_next = 2'h0;
				end
			end
			phy_next.first = (tx_idx_reg == IDX_SYNC);
			phy_next.data = tx_byte;
		end
	end

	assign phy_tx = phy_reg;
	assign phy_tx_valid = phy_valid_reg;

	// modem: alignment search and lock
	assign sync_pos = phy_rx_valid && (rx_idx_reg == IDX_SYNC);
	assign sync_good = (phy_rx_data == SYNC_BYTE);
	assign locked = (sync_reg == TSC_SYNC_LOCKED);
	assign payload_pos = phy_rx_valid && locked && pkt_ok_reg && (rx_idx_reg > IDX_CTRL);
	assign df_eff = mac_rx_eof ? TSC_DF_HUNT : df_reg;

	always_comb begin
		sync_next = sync_reg;
		rx_idx_next = rx_idx_reg;
		good_next = good_reg;
		bad_next = bad_reg;
		if (!ctrl_reg[CTRL_RX_EN]) begin
			sync_next = TSC_SYNC_HUNT;
			rx_idx_next = IDX_SYNC;
		end else if (phy_rx_valid) begin
			rx_idx_next = (rx_idx_reg == PKT_LAST) ? IDX_SYNC : rx_idx_reg + 8'h01;
			unique case (sync_reg)
				TSC_SYNC_HUNT: begin
					rx_idx_next = IDX_SYNC;
					if (sync_good) begin
						sync_next = TSC_SYNC_CONFIRM;
						rx_idx_next = IDX_PID_HI;
						good_next = 4'h1;
					end
				end
				TSC_SYNC_CONFIRM: if (sync_pos) begin
					if (!sync_good) begin
						sync_next = TSC_SYNC_HUNT;
						rx_idx_next = IDX_SYNC;
					end else if (good_reg == LOCK_GOOD - 4'h1) begin
						sync_next = TSC_SYNC_LOCKED; // [R18]
						bad_next = 4'h0;
					end else begin
						good_next = good_reg + 4'h1;
					end
				end
				TSC_SYNC_LOCKED: if (sync_pos) begin
					if (sync_good) begin
						bad_next = 4'h0;
					end else if (bad_reg == LOCK_BAD - 4'h1) begin
						sync_next = TSC_SYNC_HUNT; // [R19]
						rx_idx_next = IDX_SYNC;
					end else begin
						bad_next = bad_reg + 4'h1;
					end
				end
			endcase
		end
	end

	// modem: header check and deframing
	always_comb begin
		hdr_pstart_next = hdr_pstart_reg;
		pid_hi_next = pid_hi_reg;
		pkt_ok_next = pkt_ok_reg;
		df_next = df_eff;
		skip_next = skip_reg;
		mrx_next = mrx_reg;
		mrx_valid_next = 1'b0;
		abort_next = 1'b0;
		rx_frames_next = rx_frames_reg;
		if (phy_rx_valid && locked) begin
			if (rx_idx_reg == IDX_SYNC) begin
				pkt_ok_next = sync_good;
			end else if (rx_idx_reg == IDX_PID_HI) begin
				hdr_pstart_next = phy_rx_data[PSTART_BIT];
				pid_hi_next = phy_rx_data[4:0];
				pkt_ok_next = pkt_ok_reg && !phy_rx_data[TEI_BIT];
			end else if (rx_idx_reg == IDX_PID_LO) begin
				pkt_ok_next = pkt_ok_reg && ({pid_hi_reg, phy_rx_data} == MAC_PID); // [R03]
			end else if (rx_idx_reg == IDX_CTRL) begin
				pkt_ok_next = pkt_ok_reg && (phy_rx_data[AFC_LSB +: 2] == AFC_PAYLOAD); // [R04]
			end
		end
		if (payload_pos) begin
			mrx_next.data = phy_rx_data;
			mrx_next.first = 1'b0;
			if (hdr_pstart_reg && rx_idx_reg == IDX_POINTER) begin
				skip_next = phy_rx_data; // [R05] [R06] [R13]
			end else if (skip_reg != 8'h00) begin
				// tail of a running frame passes; otherwise skipped bytes are dropped [R09]
				skip_next = skip_reg - 8'h01;
				mrx_valid_next = (df_eff == TSC_DF_FRAME);
				if (skip_reg == 8'h01)
					df_next = TSC_DF_HUNT; // [R16]
			end else if (df_eff == TSC_DF_FRAME) begin
				mrx_valid_next = 1'b1; // [R12] [R20]
			end else if (phy_rx_data != STUFF_BYTE) begin
				// 0xff is never a frame control byte, so it is filler [R07] [R08]
				df_next = TSC_DF_FRAME;
				mrx_valid_next = 1'b1;
				mrx_next.first = 1'b1;
				rx_frames_next = rx_frames_reg + 32'h1;
			end
		end
		if (!locked) begin
			// partial frames are abandoned, the client is told once [R21]
			abort_next = (df_reg == TSC_DF_FRAME) && !mac_rx_eof;
			df_next = TSC_DF_HUNT;
			skip_next = 8'h00;
			pkt_ok_next = 1'b0;
		end
	end

	assign mac_rx = mrx_reg;
	assign mac_rx_valid = mrx_valid_reg;
	assign mac_rx_abort = abort_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RESET;
			prdata_reg <= 32'h0;
			tx_pkts_reg <= 32'h0;
			rx_frames_reg <= 32'h0;
			tx_idx_reg <= IDX_SYNC;
			cc_reg <= 4'h0;
			pstart_reg <= 1'b0;
			null_reg <= 1'b1;
			rem_reg <= 16'h0000;
			ts_left_reg <= 2'h0;
			ts_cap_reg <= 32'h0;
			phy_reg <= '0;
			phy_valid_reg <= 1'b0;
			sync_reg <= TSC_SYNC_HUNT;
			df_reg <= TSC_DF_HUNT;
			rx_idx_reg <= IDX_SYNC;
			skip_reg <= 8'h00;
			good_reg <= 4'h0;
			bad_reg <= 4'h0;
			hdr_pstart_reg <= 1'b0;
			pid_hi_reg <= 5'h00;
			pkt_ok_reg <= 1'b0;
			mrx_reg <= '0;
			mrx_valid_reg <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			prdata_reg <= prdata_next;
			tx_pkts_reg <= tx_pkts_next;
			rx_frames_reg <= rx_frames_next;
			tx_idx_reg <= tx_idx_next;
			cc_reg <= cc_next;
			pstart_reg <= pstart_next;
			null_reg <= null_next;
			rem_reg <= rem_next;
			ts_left_reg <= ts_left_next;
			ts_cap_reg <= ts_cap_next;
			phy_reg <= phy_next;
			phy_valid_reg <= phy_valid_next;
			sync_reg <= sync_next;
			df_reg <= df_next;
			rx_idx_reg <= rx_idx_next;
			skip_reg <= skip_next;
			good_reg <= good_next;
			bad_reg <= bad_next;
			hdr_pstart_reg <= hdr_pstart_next;
			pid_hi_reg <= pid_hi_next;
			pkt_ok_reg <= pkt_ok_next;
			mrx_reg <= mrx_next;
			mrx_valid_reg <= mrx_valid_next;
			abort_reg <= abort_next;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_tx_at(logic [7:0] idx);
		tx_adv && (tx_idx_reg == idx);
	endsequence
	sequence s_sync_seen;
		sync_pos && sync_good;
	endsequence
	sequence s_sync_missed;
		sync_pos && !sync_good;
	endsequence

	a_tx_sync_lead: assert property (s_tx_at(IDX_SYNC) |=> phy_reg.first && phy_reg.data == SYNC_BYTE) // [R02]
		else $error("packet does not open with sync byte");
	a_tx_packet_wrap: assert property (s_tx_at(PKT_LAST) |=> tx_idx_reg == IDX_SYNC) // [R01]
		else $error("packet length is not 188 bytes");
	a_tx_mac_pid: assert property (s_tx_at(IDX_PID_LO) && !null_reg |=> phy_reg.data == MAC_PID[7:0]) // [R03]
		else $error("mac packet carries wrong pid");
	a_tx_afc_only: assert property (s_tx_at(IDX_CTRL) |=> phy_reg.data[AFC_LSB +: 2] == AFC_PAYLOAD) // [R04]
		else $error("adaptation field control not 01");
	a_tx_offset_value: assert property (s_tx_at(IDX_POINTER) && pstart_reg |=> phy_reg.data == $past(rem_reg[7:0])) // [R16]
		else $error("offset byte does not match tail length");
	a_tx_null_fill: assert property (tx_adv && null_reg && tx_idx_reg > IDX_CTRL |=> phy_reg.data == STUFF_BYTE) // [R15]
		else $error("null packet payload not filler");
	a_rx_lock_five: assert property (sync_reg == TSC_SYNC_CONFIRM && good_reg == LOCK_GOOD - 4'h1 && ctrl_reg[CTRL_RX_EN] ##0 s_sync_seen |=> locked) // [R18]
		else $error("lock not declared after five syncs");
	a_rx_unlock_nine: assert property (locked && bad_reg == LOCK_BAD - 4'h1 && ctrl_reg[CTRL_RX_EN] ##0 s_sync_missed |=> !locked) // [R19]
		else $error("lock kept after nine bad syncs");
	a_rx_quiet_unlocked: assert property (!locked |=> !mac_rx_valid) // [R21]
		else $error("payload delivered without lock");
	a_rx_start_not_stuff: assert property (mac_rx_valid && mac_rx.first |-> mac_rx.data != STUFF_BYTE) // [R08]
		else $error("filler taken as frame start");
	a_rx_offset_skip: assert property (payload_pos && hdr_pstart_reg && rx_idx_reg == IDX_POINTER |=> !mac_rx_valid && skip_reg == $past(phy_rx_data)) // [R09]
		else $error("offset byte delivered or miscounted");
endmodule

/* testbench/tb_top.sv */
// tb_top: self-checking bench for the transport-stream convergence block.
// assumes tsc_far_end loops the sent stream back; the bench plays the MAC and software.
`timescale 1ns/1ps
module tb_top;
	import tsc_pkg::*;
	localparam logic [31:0] TS_VAL = 32'hA1B2C3D4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, ts_count;
	tsc_mac_tx_t mac_tx;
	logic mac_tx_valid, mac_tx_ready, phy_tx_valid, phy_tx_ready;
	tsc_byte_t phy_tx, mac_rx;
	logic [7:0] phy_rx_data;
	logic phy_rx_valid, mac_rx_valid, mac_rx_abort, mac_rx_eof, garble, slow;
	logic [8:0] rxq[$];
	int err_count, n_tests, n_abort;

	tsc_top tsc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mac_tx(mac_tx), .mac_tx_valid(mac_tx_valid),
		.mac_tx_ready(mac_tx_ready), .ts_count(ts_count), .phy_tx(phy_tx),
		.phy_tx_valid(phy_tx_valid), .phy_tx_ready(phy_tx_ready), .phy_rx_data(phy_rx_data),
		.phy_rx_valid(phy_rx_valid), .mac_rx(mac_rx), .mac_rx_valid(mac_rx_valid),
		.mac_rx_abort(mac_rx_abort), .mac_rx_eof(mac_rx_eof));
	tsc_far_end tsc_far_end_i (.pclk(pclk), .presetn(presetn), .phy_tx(phy_tx),
		.phy_tx_valid(phy_tx_valid), .phy_tx_ready(phy_tx_ready), .phy_rx_data(phy_rx_data),
		.phy_rx_valid(phy_rx_valid), .garble(garble), .slow(slow));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (mac_rx_valid === 1'b1)
			rxq.push_back(mac_rx);
		if (mac_rx_abort === 1'b1)
			n_abort++;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	// entered just after a rising edge; one idle edge after the access keeps a following
	// call from setting psel in the same step in which this one cleared it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r & m, x);
	endtask

	function automatic logic [8:0] q(input int j);
		return tsc_far_end_i.seen[j];
	endfunction

	function automatic int find_pkt(input logic [7:0] b1, input logic [7:0] b2);
		for (int j = 0; j + 4 < tsc_far_end_i.seen.size(); j++)
			if (q(j) === 9'h147 && q(j + 1) === {1'b0, b1} && q(j + 2) === {1'b0, b2})
				return j;
		return -1;
	endfunction

	// frame byte as it must leave: timestamp bytes replace positions 2 to 5
	function automatic logic [7:0] ex(input int i);
		if (i >= 2 && i <= 5)
			return TS_VAL[47 - 8 * i -: 8];
		return 8'(i) ^ 8'h5A;
	endfunction

	// the MAC never stalls once a frame has started
	task automatic send_frame(input int len);
		for (int i = 0; i < len; i++) begin
			mac_tx <= '{sof: i == 0, ts: i == 2, len: 16'(len), data: 8'(i) ^ 8'h5A};
			mac_tx_valid <= 1'b1;
			do @(posedge pclk); while (mac_tx_ready !== 1'b1);
		end
		mac_tx_valid <= 1'b0;
	endtask

	task automatic t_regs();
		logic [31:0] r;
		logic e;
		rd_chk(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
		rd_chk(ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
		rd_chk(ADDR_RX_FRAMES, 32'hFFFFFFFF, 32'h0);
		apb(1'b1, 8'h10, 32'h3, r, e);
		chk(e, 1'b1);
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk(e, 1'b1);
		chk(r, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h3, r, e);
		rd_chk(ADDR_CTRL, 32'h3, 32'h3);
		$display("test regs done");
	endtask

	task automatic t_lock();
		int k;
		repeat (3 * 188) @(posedge pclk);
		rd_chk(ADDR_STATUS, 32'h1, 32'h0);
		repeat (3 * 188) @(posedge pclk);
		rd_chk(ADDR_STATUS, 32'h1, 32'h1);
		k = find_pkt(8'h1F, 8'hFF);
		chk(32'(k >= 0), 32'h1);
		chk(q(k + 4), 9'h0FF);
		$display("test lock done");
	endtask

	task automatic t_frame();
		int k, p;
		send_frame(400);
		repeat (200) @(posedge pclk);
		k = find_pkt(8'h5F, 8'hFE);
		chk(32'(k >= 0), 32'h1);
		chk(q(k + 3) & 9'h0F0, 9'h010);
		chk(q(k + 4), 9'h000);
		chk(q(k + 188), 9'h147);
		chk(q(k + 189), 9'h01F);
		chk(q(k + 191) & 9'h00F, 9'((q(k + 3) + 9'h001) & 9'h00F));
		chk(q(k + 377), 9'h05F);
		chk(q(k + 380), 9'h021);
		chk(q(k + 414), 9'h0FF);
		chk(rxq.size(), 400);
		for (int j = 0; j < 400; j++) begin
			p = (j < 183) ? k + 5 + j : (j < 367) ? k + 9 + j : k + 14 + j;
			chk(q(p), {1'b0, ex(j)});
			chk(rxq[j], {j == 0, ex(j)});
		end
		rd_chk(ADDR_RX_FRAMES, 32'hFFFFFFFF, 32'h1);
		$display("test frame done");
	endtask

	task automatic t_unlock();
		garble <= 1'b1;
		send_frame(5);
		repeat (11 * 188) @(posedge pclk);
		rd_chk(ADDR_STATUS, 32'h1, 32'h0);
		chk(rxq.size(), 400);
		garble <= 1'b0;
		slow <= 1'b1;
		repeat (12 * 188) @(posedge pclk);
		rd_chk(ADDR_STATUS, 32'h1, 32'h1);
		chk(n_abort, 0);
		$display("test unlock done");
	endtask

	// a running frame is cut by the client's end marker, then the frame hunted from its tail is cut by turning rx off
	task automatic t_abort();
		logic [31:0] r;
		logic e;
		int n;
		n = 0;
		fork
			send_frame(300);
			begin
				do @(posedge pclk); while (rxq.size() < 410);
				rd_chk(ADDR_STATUS, 32'h7, 32'h7);
				mac_rx_eof <= 1'b1;
				@(posedge pclk);
				mac_rx_eof <= 1'b0;
				apb(1'b1, ADDR_CTRL, 32'h1, r, e);
			end
		join
		repeat (20) @(posedge pclk);
		chk(rxq[400], {1'b1, ex(0)});
		for (int j = 401; j < rxq.size(); j++)
			n += rxq[j][8];
		chk(n, 1);
		chk(n_abort, 1);
		chk(32'(rxq.size() < 430), 32'h1);
		rd_chk(ADDR_RX_FRAMES, 32'hFFFFFFFF, 32'h3);
		$display("test abort done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge pclk);
		err_count++;
		report_and_stop();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{mac_tx, mac_tx_valid, mac_rx_eof, garble, slow} = '0;
		ts_count = TS_VAL;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_lock();
		t_frame();
		t_unlock();
		t_abort();
		report_and_stop();
	end
endmodule

/* testbench/tsc_far_end.sv */
// tsc_far_end: behavioural modulator and demodulator standing behind the packet stream.
// assumes the block's phy ports on pclk; every accepted byte is looped back, with bit 0 flipped while garble is set.
`timescale 1ns/1ps
module tsc_far_end
	import tsc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// modulator side
	input wire tsc_pkg::tsc_byte_t phy_tx,
	input wire logic phy_tx_valid,
	output logic phy_tx_ready,
	// demodulator side
	output logic [7:0] phy_rx_data,
	output logic phy_rx_valid,
	// scenario controls
	input wire logic garble,
	input wire logic slow
);
	logic [8:0] seen[$];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_tx_ready <= 1'b0;
			phy_rx_valid <= 1'b0;
			phy_rx_data <= 8'h00;
		end else begin
			// a slow modulator takes a byte every other cycle
			phy_tx_ready <= slow ? !phy_tx_ready : 1'b1;
			if (phy_tx_valid && phy_tx_ready) begin
				seen.push_back(phy_tx);
				// garble flips bit 0 so every sync byte turns bad
				phy_rx_data <= phy_tx.data ^ {7'h00, garble};
				phy_rx_valid <= 1'b1;
			end else begin
				// idle line never repeats the last byte
				phy_rx_data <= ~phy_rx_data;
				phy_rx_valid <= 1'b0;
			end
		end
	end
endmodule
